// ===== shared/refladder_pkg.sv
package refladder_pkg;

  // register indices as printed; byte address is four times the index
  localparam logic [7:0] COMPARATOR_CONTROL_IDX = 8'h9c;
  localparam logic [7:0] REFERENCE_CONTROL_IDX = 8'h9d;
  localparam logic [11:0] COMPARATOR_CONTROL_ADDR = {2'h0, COMPARATOR_CONTROL_IDX, 2'h0};
  localparam logic [11:0] REFERENCE_CONTROL_ADDR = {2'h0, REFERENCE_CONTROL_IDX, 2'h0};
  localparam int ADDR_W = 12;

  localparam logic [7:0] COMPARATOR_CONTROL_RST = 8'h07;
  localparam logic [7:0] REFERENCE_CONTROL_RST = 8'h00;

  // reference_control fields
  localparam int REF_POWER_ON_BIT = 7;
  localparam int REF_PIN_DRIVE_BIT = 6;
  localparam int REF_RANGE_SEL_BIT = 5;
  localparam int REF_UNUSED_BIT = 4;
  localparam int REF_TAP_MSB = 3;
  localparam int REF_TAP_LSB = 0;
  localparam logic [7:0] REF_WRITE_MASK = 8'hef;

  // comparator_control fields
  localparam int CMP_OUT_MSB = 7;
  localparam int CMP_OUT_LSB = 6;
  localparam logic [7:0] CMP_WRITE_MASK = 8'h3f;
  localparam logic [2:0] MODE_INTERNAL_REF = 3'h6;

  // reference level expressed in 96ths of the source supply (lcm of 24 and 32)
  localparam int LADDER_TAPS = 16;
  localparam logic [7:0] LEVEL_DENOM = 8'h60;
  localparam logic [7:0] LOW_RANGE_BASE = 8'h18;
  localparam logic [7:0] WIDE_RANGE_STEP = 8'h04;
  localparam logic [7:0] LOW_RANGE_STEP = 8'h03;

  typedef struct packed {
    logic power_on;
    logic pin_drive;
    logic range_sel;
    logic unused;
    logic [3:0] tap_value;
  } ref_ctrl_s;

  typedef struct packed {
    logic [1:0] cmp_out;
    logic [1:0] invert;
    logic input_switch;
    logic [2:0] mode_sel;
  } cmp_ctrl_s;

  typedef struct packed {
    logic power;
    logic [LADDER_TAPS-1:0] tap_sel;
    logic [7:0] level_frac96;
  } ladder_s;

endpackage : refladder_pkg

// ===== rtl/tap_decoder.sv
`timescale 1ns/10ps
`default_nettype none
module tap_decoder
  import refladder_pkg::*;
(
  input wire ref_ctrl_s ctrl,
  output ladder_s ladder
);

  function automatic logic [LADDER_TAPS-1:0] onehot_tap(input logic [3:0] tap);
    onehot_tap = '0;
    onehot_tap[tap] = 1'b1;
  endfunction : onehot_tap

  function automatic logic [7:0] level96(input logic wide, input logic [3:0] tap);
    if (wide) begin
      level96 = 8'(WIDE_RANGE_STEP * {4'h0, tap});
    end else begin
      level96 = 8'(LOW_RANGE_BASE + LOW_RANGE_STEP * {4'h0, tap});
    end
  endfunction : level96

  always_comb begin
    ladder.power = ctrl.power_on;
    // unpowered ladder selects no tap and yields no level
    ladder.tap_sel = ctrl.power_on ? onehot_tap(ctrl.tap_value) : '0;
    ladder.level_frac96 = ctrl.power_on ? level96(ctrl.range_sel, ctrl.tap_value) : 8'h00;
  end

endmodule : tap_decoder
`default_nettype wire

// ===== rtl/comparator_reference_ladder_control.sv
// Operation
// - the comparators get a reference from the sixteen-tap ladder when the mode field is 110.
// - with range select 1 the level is tap/24 of the source supply, from 0 to 0.625.
// - with range select 0 the level is 1/4 plus tap/32 of the source, from 0.25 to 0.71875.
// - the ladder is powered down while the power enable bit is clear.
// - with the output enable bit set the reference is routed to the shared analog pin.
// - power enable is bit 7, pin drive bit 6, range select bit 5, tap value bits 3 to 0.
// - every reset clears the reference register; bit 4 reads zero and ignores writes.
// - in internal-reference mode the reference feeds the non-inverting input of both comparators.
//
// Our own choice: register access over APB.
`timescale 1ns/10ps
`default_nettype none
module comparator_reference_ladder_control
  import refladder_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] comparator_out,
  output logic ref_ladder_power,
  output logic [LADDER_TAPS-1:0] ladder_tap_sel,
  output logic [7:0] ref_output_level,
  output logic ref_pin_route,
  output logic [1:0] vin_plus_internal,
  output logic [2:0] comparator_mode_sel
);

  ref_ctrl_s ref_q, ref_d;
  cmp_ctrl_s cmp_q, cmp_d;
  ladder_s ladder_q, ladder_d;
  logic pin_q, pin_d;
  logic [1:0] vinp_q, vinp_d;
  logic [31:0] rdata_q, rdata_d;
  logic rdy_q, rdy_d;
  logic err_q, err_d;
  logic [1:0] cmp_sync1_q, cmp_sync2_q;
  logic setup, wr_fire, hit_ref, hit_cmp;

  // comparator outputs are asynchronous to pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_sync1_q <= 2'b00;
      cmp_sync2_q <= 2'b00;
    end else begin
      cmp_sync1_q <= comparator_out;
      cmp_sync2_q <= cmp_sync1_q;
    end
  end

  assign setup = psel && !penable;
  assign hit_ref = paddr == REFERENCE_CONTROL_ADDR;
  assign hit_cmp = paddr == COMPARATOR_CONTROL_ADDR;
  // no wait state: answer in the first access cycle, write lands at that edge
  assign wr_fire = psel && penable && rdy_q && pwrite && pstrb[0] && !err_q;

  always_comb begin
    ref_d = ref_q;
    cmp_d = cmp_q;
    cmp_d.cmp_out = cmp_sync2_q;
    if (wr_fire && hit_ref) begin
      ref_d = ref_ctrl_s'(pwdata[7:0] & REF_WRITE_MASK);
    end
    if (wr_fire && hit_cmp) begin
      cmp_d = cmp_ctrl_s'({cmp_sync2_q, pwdata[5:0]});
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_q <= ref_ctrl_s'(REFERENCE_CONTROL_RST);
      cmp_q <= cmp_ctrl_s'(COMPARATOR_CONTROL_RST);
    end else begin
      ref_q <= ref_d;
      cmp_q <= cmp_d;
    end
  end

  // decoding from the next value keeps outputs in step with the register
  tap_decoder u_dec (
    .ctrl(ref_d),
    .ladder(ladder_d)
  );

  always_comb begin
    pin_d = ref_d.pin_drive;
    // both comparators share the one internal reference
    vinp_d = (cmp_d.mode_sel == MODE_INTERNAL_REF) ? 2'b11 : 2'b00;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ladder_q <= '0;
      pin_q <= 1'b0;
      vinp_q <= 2'b00;
    end else begin
      ladder_q <= ladder_d;
      pin_q <= pin_d;
      vinp_q <= vinp_d;
    end
  end

  always_comb begin
    rdy_d = setup;
    // registered so pslverr stands exactly in the access cycle, like pready
    err_d = setup && !(hit_ref || hit_cmp);
    rdata_d = rdata_q;
    if (setup) begin
      rdata_d = 32'h0000_0000;
      if (!pwrite && hit_ref) begin
        rdata_d = {24'h000000, ref_q};
      end
      if (!pwrite && hit_cmp) begin
        rdata_d = {24'h000000, cmp_sync2_q, cmp_q[5:0]};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy_q <= 1'b0;
      err_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      rdy_q <= rdy_d;
      err_q <= err_d;
      rdata_q <= rdata_d;
    end
  end

  assign prdata = rdata_q;
  assign pready = rdy_q;
  assign pslverr = err_q;
  assign ref_ladder_power = ladder_q.power;
  assign ladder_tap_sel = ladder_q.tap_sel;
  assign ref_output_level = ladder_q.level_frac96;
  assign ref_pin_route = pin_q;
  assign vin_plus_internal = vinp_q;
  assign comparator_mode_sel = cmp_q.mode_sel;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_write_fields;
    (psel && penable && pready && !pslverr && pwrite && pstrb[0] && hit_ref) |=>
      (ref_q == ref_ctrl_s'({$past(pwdata[7:5]), 1'b0, $past(pwdata[3:0])}));
  endproperty
  a_write_fields: assert property (p_write_fields) else $error("reference write mismatch");

  property p_read_unused_zero;
    (setup && !pwrite && hit_ref) |=> (prdata[4] == 1'b0 && prdata[7:0] == ref_q);
  endproperty
  a_read_unused_zero: assert property (p_read_unused_zero) else $error("bit 4 not zero");

  property p_power_follows;
    ##1 (ref_ladder_power == ref_q.power_on);
  endproperty
  a_power_follows: assert property (p_power_follows) else $error("ladder power wrong");

  property p_tap_onehot;
    ref_q.power_on |-> (ladder_tap_sel == (16'h0001 << ref_q.tap_value));
  endproperty
  a_tap_onehot: assert property (p_tap_onehot) else $error("tap selection wrong");

  property p_off_no_tap;
    !ref_q.power_on |-> (ladder_tap_sel == 16'h0000 && ref_output_level == 8'h00);
  endproperty
  a_off_no_tap: assert property (p_off_no_tap) else $error("ladder active while off");

  property p_wide_range;
    (ref_q.power_on && ref_q.range_sel) |-> (ref_output_level == {2'b00, ref_q.tap_value, 2'b00});
  endproperty
  a_wide_range: assert property (p_wide_range) else $error("wide range level wrong");

  property p_low_range;
    (ref_q.power_on && !ref_q.range_sel) |->
      (ref_output_level == 8'(8'd24 + 8'd3 * {4'h0, ref_q.tap_value}));
  endproperty
  a_low_range: assert property (p_low_range) else $error("low range level wrong");

  property p_pin_route;
    $rose(ref_q.pin_drive) |-> ref_pin_route ##1 (ref_pin_route == ref_q.pin_drive);
  endproperty
  a_pin_route: assert property (p_pin_route) else $error("pin route wrong");

  property p_internal_mode;
    ##1 (vin_plus_internal == {2{cmp_q.mode_sel == MODE_INTERNAL_REF}});
  endproperty
  a_internal_mode: assert property (p_internal_mode) else $error("reference not on inputs");

  property p_answer;
    setup |=> (pready ##1 !pready);
  endproperty
  a_answer: assert property (p_answer) else $error("apb answer timing wrong");

  c_wide: cover property (ref_q.power_on && ref_q.range_sel && ref_q.tap_value == 4'hf);
  c_low: cover property (ref_q.power_on && !ref_q.range_sel && ref_q.tap_value == 4'hf);
  c_internal: cover property (vin_plus_internal == 2'b11 && ref_ladder_power);
  c_unmapped: cover property (pslverr);

endmodule : comparator_reference_ladder_control
`default_nettype wire

// ===== verif/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import refladder_pkg::*;
();
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic ref_ladder_power, ref_pin_route;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [1:0] comparator_out, vin_plus_internal;
  logic [LADDER_TAPS-1:0] ladder_tap_sel, prev_sel;
  logic [7:0] ref_output_level;
  logic [2:0] comparator_mode_sel;
  int n_errors, total_checks;

  comparator_reference_ladder_control i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .comparator_out(comparator_out), .ref_ladder_power(ref_ladder_power),
    .ladder_tap_sel(ladder_tap_sel), .ref_output_level(ref_output_level),
    .ref_pin_route(ref_pin_route), .vin_plus_internal(vin_plus_internal),
    .comparator_mode_sel(comparator_mode_sel)
  );

  always #20 pclk = ~pclk;

  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // setup then access; request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_errors++;
      stop_test();
    end
  endtask : apb

  task automatic rdchk(input string what, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 4'hf);
    check(what, rd, exp);
  endtask : rdchk

  // outputs settle on the write edge, so look half a cycle later
  task automatic outs(input logic [7:0] lvl, input logic pw, input logic rt);
    @(negedge pclk);
    check("level", {24'h0, ref_output_level}, {24'h0, lvl});
    check("power", {31'h0, ref_ladder_power}, {31'h0, pw});
    check("route", {31'h0, ref_pin_route}, {31'h0, rt});
    check("tap_sel", {31'h0, pw ? $onehot(ladder_tap_sel) : (ladder_tap_sel == '0)}, 32'h1);
  endtask : outs

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
    pstrb = 4'h0;
    comparator_out = 2'h0;
    n_errors = 0;
    total_checks = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    check("mode_rst", {29'h0, comparator_mode_sel}, 32'h7);
    outs(8'h00, 1'b0, 1'b0);
    rdchk("ref_rst", REFERENCE_CONTROL_ADDR, 32'h00);
    rdchk("cmp_rst", COMPARATOR_CONTROL_ADDR, 32'h07);
    apb(1'b1, REFERENCE_CONTROL_ADDR, 32'hff, 4'hf);
    outs(8'h3c, 1'b1, 1'b1);
    rdchk("ref_bit4", REFERENCE_CONTROL_ADDR, 32'hef);
    for (int r = 0; r < 2; r++) begin
      for (int t = 0; t < LADDER_TAPS; t++) begin
        apb(1'b1, REFERENCE_CONTROL_ADDR, {24'h0, 2'b10, r[0], 1'b0, t[3:0]}, 4'hf);
        outs(8'(r ? 4 * t : 24 + 3 * t), 1'b1, 1'b0);
        check("tap_pos", {16'h0, ladder_tap_sel}, 32'h1 << t);
        if (t > 0) check("tap_moved", {31'h0, ladder_tap_sel != prev_sel}, 32'h1);
        prev_sel = ladder_tap_sel;
      end
    end
    apb(1'b1, REFERENCE_CONTROL_ADDR, 32'h65, 4'hf);
    outs(8'h00, 1'b0, 1'b1);
    apb(1'b1, COMPARATOR_CONTROL_ADDR, 32'h06, 4'hf);
    @(negedge pclk);
    check("vin_plus", {30'h0, vin_plus_internal}, 32'h3);
    check("mode", {29'h0, comparator_mode_sel}, 32'h6);
    apb(1'b1, COMPARATOR_CONTROL_ADDR, 32'h05, 4'hf);
    @(negedge pclk);
    check("vin_plus_off", {30'h0, vin_plus_internal}, 32'h0);
    // refused writes must leave the register alone
    apb(1'b1, REFERENCE_CONTROL_ADDR, 32'h8f, 4'h0);
    check("nostrb_err", {31'h0, err}, 32'h0);
    rdchk("ref_nostrb", REFERENCE_CONTROL_ADDR, 32'h65);
    apb(1'b1, 12'h278, 32'hff, 4'hf);
    check("wr_err", {31'h0, err}, 32'h1);
    apb(1'b0, 12'h000, 32'h0, 4'hf);
    check("rd_err", {31'h0, err}, 32'h1);
    check("rd_unmapped", rd, 32'h0);
    rdchk("ref_kept", REFERENCE_CONTROL_ADDR, 32'h65);
    comparator_out <= 2'h3;
    repeat (4) @(posedge pclk);
    rdchk("cmp_out", COMPARATOR_CONTROL_ADDR, 32'hc5);
    // second reset in mid-run with the ladder powered
    apb(1'b1, REFERENCE_CONTROL_ADDR, 32'hea, 4'hf);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    outs(8'h00, 1'b0, 1'b0);
    repeat (4) @(posedge pclk);
    rdchk("ref_rst2", REFERENCE_CONTROL_ADDR, 32'h00);
    rdchk("cmp_rst2", COMPARATOR_CONTROL_ADDR, 32'hc7);
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
